// >>> gpio_pin_group_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef GPIO_PIN_GROUP_MAP_VH
`define GPIO_PIN_GROUP_MAP_VH

`define GPIO_PINS          32
`define GPIO_SAMPLE_GROUPS 4

`define REG_DIR            8'h00
`define REG_DIRCLR         8'h04
`define REG_DIRSET         8'h08
`define REG_DIRTGL         8'h0C
`define REG_OUT            8'h10
`define REG_OUTCLR         8'h14
`define REG_OUTSET         8'h18
`define REG_OUTTGL         8'h1C
`define REG_IN             8'h20
`define REG_CTRL           8'h24
`define REG_INEN           8'h28
`define REG_PULLEN         8'h2C
`define REG_ROUTE          8'h30
`define REG_ANALOG         8'h34
`define REG_DBGHALT        8'h38
`define REG_DRIVE          8'h3C

`define OP_WRITE           2'h0
`define OP_CLEAR           2'h1
`define OP_SET             2'h2
`define OP_TOGGLE          2'h3

`define CTRL_SAMPLING_LSB  0
`define CTRL_SAMPLING_MSB  3
`define DBGHALT_BIT        0

`define RESET_WORD         32'h00000000
`define RESET_CTRL         4'h0

`define SYNC_DELAY_CYCLES  2'h2

`endif

// >>> gpio_input_sync.v
// two-stage input synchroniser, clocked per pin by an enable
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_group_map.vh"
module gpio_input_sync (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [31:0] padIn,
    input  wire [31:0] sampleEn,
    output reg  [31:0] syncIn
);
    reg [31:0] stageOne;

    // stages load only when enabled; pins not enabled hold their last value
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stageOne <= `RESET_WORD;
            syncIn   <= `RESET_WORD;
        end else begin
            stageOne <= (stageOne & ~sampleEn) | (padIn & sampleEn);
            syncIn   <= (syncIn & ~sampleEn) | (stageOne & sampleEn);
        end
    end
endmodule // gpio_input_sync
`default_nettype wire

// >>> gpio_pad_mux.v
// per-pad output, enable, pull and input-buffer selection
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_group_map.vh"
module gpio_pad_mux (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        hold,
    input  wire [31:0] dir,
    input  wire [31:0] outLevel,
    input  wire [31:0] inEn,
    input  wire [31:0] pullEn,
    input  wire [31:0] route,
    input  wire [31:0] analog,
    input  wire [31:0] periphOut,
    input  wire [31:0] periphOe,
    output reg  [31:0] padOut,
    output reg  [31:0] padOe,
    output reg  [31:0] padInEn,
    output reg  [31:0] padPullEn,
    output reg  [31:0] padPullUp
);
    wire [31:0] digital;

    assign digital = ~analog;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            padOut    <= `RESET_WORD;
            padOe     <= `RESET_WORD;
            padInEn   <= `RESET_WORD;
            padPullEn <= `RESET_WORD;
            padPullUp <= `RESET_WORD;
        end else if (!hold) begin
            padOut    <= digital & ((route & periphOut) |
                         (~route & outLevel));
            padOe     <= digital & ((route & periphOe) |
                         (~route & dir));
            // routed pads keep their buffer so the peripheral reads them
            padInEn   <= digital & (inEn | route);
            // an enabled driver always cancels pull
            padPullEn <= digital & ~route & ~dir & pullEn;
            padPullUp <= outLevel;
        end
    end
endmodule // gpio_pad_mux
`default_nettype wire

// >>> gpio_pin_group_controller.v
// one 32-pin group: register file, two access paths, pad control
// Function
// - one group of 32 individually controlled lines
// - each pin input or output, driver, pull
// - atomic byte/half/word set, clear, toggle
// - direction, output, input reachable from both buses
// - reset: input, buffer, driver, pull off
// - keeps running in sleep while clocked
// - local bus and bridge on the clock
// - local bus served first on collision
// - bridge access delayed one cycle at most
// - routed pin: peripheral drives and reads pad
// - analog selection disables all digital pad features
// - continues normally while processor debug-halted
// - setting can halt controller during debug halt
// - write guard rejects register writes
// - debugger writes bypass the write guard
// - local bus single cycle, no wait
// - local bus byte, halfword, word sizes
// - local bus: dir/out all ops, input read
// - direction one output, zero input
// - output bit one high, zero low
// - on-demand input read waits two cycles
// - pull direction follows the output bit
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_group_map.vh"
module gpio_pin_group_controller (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [7:0]  avAddress,
    input  wire        avRead,
    input  wire        avWrite,
    input  wire [31:0] avWritedata,
    input  wire [3:0]  avByteenable,
    input  wire        avDebugAccess,
    output reg  [31:0] avReaddata,
    output reg         avWaitrequest,
    input  wire        lbSel,
    input  wire        lbWrite,
    input  wire [7:0]  lbAddress,
    input  wire [3:0]  lbByteEn,
    input  wire [31:0] lbWdata,
    output reg  [31:0] lbRdata,
    input  wire        writeGuard,
    input  wire        dbgHalted,
    input  wire [31:0] padIn,
    input  wire [31:0] periphOut,
    input  wire [31:0] periphOe,
    output reg  [31:0] periphIn,
    output wire [31:0] padOut,
    output wire [31:0] padOe,
    output wire [31:0] padInEn,
    output wire [31:0] padPullEn,
    output wire [31:0] padPullUp,
    output reg  [31:0] padDrive
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SYNC = 2'h1;
    localparam [1:0] ST_ACK  = 2'h2;

    reg  [31:0] dir;
    reg  [31:0] outLevel;
    reg  [31:0] inEn;
    reg  [31:0] pullEn;
    reg  [31:0] route;
    reg  [31:0] analog;
    reg  [3:0]  sampling;
    reg         haltSetting;
    reg  [1:0]  state;
    reg  [1:0]  syncCount;
    reg         delayed;
    reg  [31:0] next_dir;
    reg  [31:0] next_outLevel;
    reg  [31:0] avReadValue;
    reg  [31:0] lbReadValue;
    wire [31:0] syncIn;
    wire [31:0] sampleEn;
    wire [31:0] continuousEn;
    wire [31:0] avMask;
    wire [31:0] lbMask;
    wire        frozen;
    wire        avReq;
    wire        collide;
    wire        avNeedsSync;
    wire        avCommit;
    wire        avWriteOk;
    wire        lbWriteOk;
    wire        lbRead;

    // widen byte enables to a bit mask
    function [31:0] byteMask;
        input [3:0] be;
        begin
            byteMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // masked write, clear, set or toggle
    function [31:0] applyOp;
        input [31:0] cur;
        input [31:0] data;
        input [31:0] mask;
        input [1:0]  op;
        reg   [31:0] bits;
        begin
            bits = data & mask;
            case (op)
                `OP_WRITE:  applyOp = (cur & ~mask) | bits;
                `OP_CLEAR:  applyOp = cur & ~bits;
                `OP_SET:    applyOp = cur | bits;
                `OP_TOGGLE: applyOp = cur ^ bits;
                default:    applyOp = cur;
            endcase
        end
    endfunction

    // operation of a direction or output alias, by offset
    function [1:0] opOf;
        input [7:0] addr;
        begin
            case (addr[3:2])
                2'h0:    opOf = `OP_WRITE;
                2'h1:    opOf = `OP_CLEAR;
                2'h2:    opOf = `OP_SET;
                default: opOf = `OP_TOGGLE;
            endcase
        end
    endfunction

    function isDir;
        input [7:0] addr;
        begin
            isDir = (addr[7:4] == 4'h0) && (addr[1:0] == 2'h0);
        end
    endfunction

    function isOut;
        input [7:0] addr;
        begin
            isOut = (addr[7:4] == 4'h1) && (addr[1:0] == 2'h0);
        end
    endfunction

    assign avMask = byteMask(avByteenable);
    assign lbMask = byteMask(lbByteEn);
    assign frozen = dbgHalted & haltSetting;

    // each sampling bit covers eight pins
    assign continuousEn = {{8{sampling[3]}}, {8{sampling[2]}},
                           {8{sampling[1]}}, {8{sampling[0]}}};
    assign sampleEn = frozen ? 32'h00000000 :
        inEn & ~analog & (continuousEn |
        {32{(state == ST_SYNC) | (avReq & avNeedsSync)}});

    assign avReq = (avRead | avWrite) & (state == ST_IDLE);
    assign collide = avReq & lbSel & ~delayed;
    assign avNeedsSync = avRead & (avAddress == `REG_IN) &
        ~(&sampling);
    assign avCommit = avReq & ~collide & ~avNeedsSync;
    assign avWriteOk = avCommit & avWrite &
        (~writeGuard | avDebugAccess);
    assign lbWriteOk = lbSel & lbWrite & ~writeGuard;
    assign lbRead = lbSel & ~lbWrite;

    // local write first, the bridge write then applies on top
    always @* begin
        next_dir = dir;
        next_outLevel = outLevel;
        if (lbWriteOk && isDir(lbAddress)) begin
            next_dir = applyOp(next_dir, lbWdata, lbMask,
                opOf(lbAddress));
        end
        if (lbWriteOk && isOut(lbAddress)) begin
            next_outLevel = applyOp(next_outLevel, lbWdata, lbMask,
                opOf(lbAddress));
        end
        if (avWriteOk && isDir(avAddress)) begin
            next_dir = applyOp(next_dir, avWritedata, avMask,
                opOf(avAddress));
        end
        if (avWriteOk && isOut(avAddress)) begin
            next_outLevel = applyOp(next_outLevel, avWritedata, avMask,
                opOf(avAddress));
        end
    end

    // bridge read view; unmapped offsets read as zero
    always @* begin
        avReadValue = 32'h00000000;
        if (isDir(avAddress)) begin
            avReadValue = dir;
        end else if (isOut(avAddress)) begin
            avReadValue = outLevel;
        end else begin
            case (avAddress)
                `REG_IN:      avReadValue = syncIn;
                `REG_CTRL:    avReadValue = {28'h0000000, sampling};
                `REG_INEN:    avReadValue = inEn;
                `REG_PULLEN:  avReadValue = pullEn;
                `REG_ROUTE:   avReadValue = route;
                `REG_ANALOG:  avReadValue = analog;
                `REG_DBGHALT: avReadValue = {31'h00000000, haltSetting};
                `REG_DRIVE:   avReadValue = padDrive;
                default:      avReadValue = 32'h00000000;
            endcase
        end
    end

    // local bus sees only direction, output and input
    always @* begin
        lbReadValue = 32'h00000000;
        if (isDir(lbAddress)) begin
            lbReadValue = dir;
        end else if (isOut(lbAddress)) begin
            lbReadValue = outLevel;
        end else if (lbAddress == `REG_IN) begin
            // no wait possible, so stale unless sampling is continuous
            lbReadValue = syncIn;
        end
    end

    // pin state, sampled on every edge; no sleep gating here
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dir      <= `RESET_WORD;
            outLevel <= `RESET_WORD;
        end else begin
            dir      <= next_dir;
            outLevel <= next_outLevel;
        end
    end

    // configuration registers, bridge only
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inEn        <= `RESET_WORD;
            pullEn      <= `RESET_WORD;
            route       <= `RESET_WORD;
            analog      <= `RESET_WORD;
            sampling    <= `RESET_CTRL;
            haltSetting <= 1'b0;
            padDrive    <= `RESET_WORD;
        end else if (avWriteOk) begin
            case (avAddress)
                `REG_INEN: begin
                    inEn <= applyOp(inEn, avWritedata, avMask,
                        `OP_WRITE);
                end
                `REG_PULLEN: begin
                    pullEn <= applyOp(pullEn, avWritedata, avMask,
                        `OP_WRITE);
                end
                `REG_ROUTE: begin
                    route <= applyOp(route, avWritedata, avMask,
                        `OP_WRITE);
                end
                `REG_ANALOG: begin
                    analog <= applyOp(analog, avWritedata, avMask,
                        `OP_WRITE);
                end
                `REG_CTRL: begin
                    if (avByteenable[0]) begin
                        sampling <= avWritedata[`CTRL_SAMPLING_MSB:
                            `CTRL_SAMPLING_LSB];
                    end
                end
                `REG_DBGHALT: begin
                    if (avByteenable[0]) begin
                        haltSetting <= avWritedata[`DBGHALT_BIT];
                    end
                end
                `REG_DRIVE: begin
                    padDrive <= applyOp(padDrive, avWritedata, avMask,
                        `OP_WRITE);
                end
                default: begin
                    haltSetting <= haltSetting;
                end
            endcase
        end
    end

    // bridge handshake: idle, optional sync wait, one acknowledge cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state         <= ST_IDLE;
            syncCount     <= 2'h0;
            delayed       <= 1'b0;
            avWaitrequest <= 1'b1;
            avReaddata    <= `RESET_WORD;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (collide) begin
                        delayed <= 1'b1;
                    end else if (avReq && avNeedsSync) begin
                        delayed   <= 1'b0;
                        // first stage loads on this edge, keeping two cycles
                        syncCount <= 2'h1;
                        state     <= ST_SYNC;
                    end else if (avCommit) begin
                        delayed       <= 1'b0;
                        avReaddata    <= avRead ? avReadValue :
                                         32'h00000000;
                        avWaitrequest <= 1'b0;
                        state         <= ST_ACK;
                    end
                end
                ST_SYNC: begin
                    if (syncCount == `SYNC_DELAY_CYCLES) begin
                        avReaddata    <= syncIn;
                        avWaitrequest <= 1'b0;
                        state         <= ST_ACK;
                    end else begin
                        syncCount <= syncCount + 2'h1;
                    end
                end
                ST_ACK: begin
                    avWaitrequest <= 1'b1;
                    state         <= ST_IDLE;
                end
                default: begin
                    avWaitrequest <= 1'b1;
                    state         <= ST_IDLE;
                end
            endcase
        end
    end

    // local bus answers on the next edge, always, with no wait
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lbRdata <= `RESET_WORD;
        end else if (lbRead) begin
            lbRdata <= lbReadValue;
        end
    end

    // routed peripherals see the physical pad level
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            periphIn <= `RESET_WORD;
        end else if (!frozen) begin
            periphIn <= padIn & route & ~analog;
        end
    end

    gpio_input_sync inputSync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .padIn    (padIn),
        .sampleEn (sampleEn),
        .syncIn   (syncIn)
    );

    gpio_pad_mux padMux (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .hold      (frozen),
        .dir       (dir),
        .outLevel  (outLevel),
        .inEn      (inEn),
        .pullEn    (pullEn),
        .route     (route),
        .analog    (analog),
        .periphOut (periphOut),
        .periphOe  (periphOe),
        .padOut    (padOut),
        .padOe     (padOe),
        .padInEn   (padInEn),
        .padPullEn (padPullEn),
        .padPullUp (padPullUp)
    );
endmodule // gpio_pin_group_controller
`default_nettype wire

// >>> gpio_group_checker.sv
// concurrent checks on the pin group controller ports
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_group_map.vh"
module gpio_group_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avAddress,
    input wire logic        avRead,
    input wire logic        avWrite,
    input wire logic        avDebugAccess,
    input wire logic [31:0] avReaddata,
    input wire logic        avWaitrequest,
    input wire logic        lbSel,
    input wire logic        lbWrite,
    input wire logic [31:0] lbRdata,
    input wire logic        writeGuard,
    input wire logic        dbgHalted,
    input wire logic [31:0] padIn,
    input wire logic [31:0] periphIn,
    input wire logic [31:0] padOe,
    input wire logic [31:0] padInEn,
    input wire logic [31:0] padPullEn,
    input wire logic [31:0] padDrive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire guardWr = avWrite && writeGuard && !avDebugAccess;
    property p_rst_quiet;
        disable iff (1'b0) rst |-> !(padOe | padInEn | padPullEn) && avWaitrequest;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("pads on in reset");
    // IN reads may wait for the synchroniser, so they are left out here
    property p_ack_bound;
        (avRead || avWrite) && avWaitrequest && avAddress != `REG_IN
            |-> ##[1:3] !avWaitrequest;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("late ack");
    property p_in_bound;
        avRead && avAddress == `REG_IN && avWaitrequest
            |-> ##[1:4] !avWaitrequest;
    endproperty
    a_in_bound: assert property (p_in_bound) else $error("late in");
    property p_rdata_hold; $changed(avReaddata) |-> $fell(avWaitrequest); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_lb_hold; !(lbSel && !lbWrite) |=> $stable(lbRdata); endproperty
    a_lb_hold: assert property (p_lb_hold) else $error("lbRdata moved");
    property p_no_pull_drive; (padOe & padPullEn) == 32'h0; endproperty
    a_no_pull_drive: assert property (p_no_pull_drive) else $error("pull+drv");
    property p_periph_pad;
        !dbgHalted && !$past(dbgHalted) |-> (periphIn & ~$past(padIn)) == 32'h0;
    endproperty
    a_periph_pad: assert property (p_periph_pad) else $error("periphIn wrong");
    property p_drive_cause;
        $changed(padDrive) |-> $fell(avWaitrequest) && $past(avWrite);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("stray drive");
    property p_guard_drop;
        $fell(avWaitrequest) && $past(guardWr) |-> $stable(padDrive);
    endproperty
    a_guard_drop: assert property (p_guard_drop) else $error("guard broken");
    c_collision: cover property (avWrite && avWaitrequest && lbSel && lbWrite);
    c_guard: cover property ($fell(avWaitrequest) && $past(guardWr));
    c_in_read: cover property (avRead && avAddress == `REG_IN && !avWaitrequest);
endmodule // gpio_group_checker
bind gpio_pin_group_controller gpio_group_checker chk (
    .sys_clk, .rst, .avAddress, .avRead, .avWrite, .avDebugAccess,
    .avReaddata, .avWaitrequest, .lbSel, .lbWrite, .lbRdata, .writeGuard,
    .dbgHalted, .padIn, .periphIn, .padOe, .padInEn, .padPullEn, .padDrive);
`default_nettype wire

// >>> gpio_pad_model.sv
// pad-side model: resolves each pin from driver and pulls
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_model (
    input  wire logic        sys_clk,
    input  wire logic [31:0] padOut,
    input  wire logic [31:0] padOe,
    input  wire logic [31:0] padPullEn,
    input  wire logic [31:0] padPullUp,
    output wire logic [31:0] padIn
);
    // a floating pin flips each cycle so no test leans on a settled x
    logic [31:0] floatLevel = 32'h0;
    always @(posedge sys_clk) floatLevel <= ~floatLevel;
    assign padIn = (padOe & padOut) | (~padOe & padPullEn & padPullUp)
        | (~padOe & ~padPullEn & floatLevel);
endmodule // gpio_pad_model
`default_nettype wire

// >>> gpio_pin_group_controller_test.sv
// randomised self-checking bench for the pin group controller
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_group_map.vh"
module gpio_pin_group_controller_test;
    logic        sys_clk, rst, avRead, avWrite, avDebugAccess, sel;
    logic        lbSel, lbWrite, writeGuard, dbgHalted;
    logic [7:0]  avAddress, lbAddress, ad;
    logic [3:0]  avByteenable, lbByteEn, be;
    logic [31:0] avWritedata, lbWdata, periphOut, periphOe;
    logic [31:0] dirM, outM, d, rd, pat;
    logic [1:0]  op;
    wire  [31:0] avReaddata, lbRdata, padIn, periphIn, padOut, padOe;
    wire  [31:0] padInEn, padPullEn, padPullUp, padDrive;
    wire         avWaitrequest;
    integer      seed, failures, checkCount, waitN, i;
    logic [3:0]  beTab [0:6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
    gpio_pin_group_controller dut (
        .sys_clk, .rst, .avAddress, .avRead, .avWrite, .avWritedata,
        .avByteenable, .avDebugAccess, .avReaddata, .avWaitrequest,
        .lbSel, .lbWrite, .lbAddress, .lbByteEn, .lbWdata, .lbRdata,
        .writeGuard, .dbgHalted, .padIn, .periphOut, .periphOe, .periphIn,
        .padOut, .padOe, .padInEn, .padPullEn, .padPullUp, .padDrive);
    gpio_pad_model pads (
        .sys_clk, .padOut, .padOe, .padPullEn, .padPullUp, .padIn);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] apply(input logic [31:0] c, v,
            input logic [3:0] b, input logic [1:0] o);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        case (o)
            `OP_WRITE: apply = (c & ~m) | (v & m);
            `OP_CLEAR: apply = c & ~(v & m);
            `OP_SET:   apply = c | (v & m);
            default:   apply = c ^ (v & m);
        endcase
    endfunction
    task automatic check(input logic [31:0] got, exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low; one idle edge after
    task automatic avXfer(input logic w, input logic [7:0] a,
            input logic [31:0] v, input logic [3:0] b);
        avAddress <= a;
        avWrite <= w;
        avRead <= !w;
        avWritedata <= v;
        avByteenable <= b;
        waitN = 0;
        do begin
            @(posedge sys_clk);
            waitN++;
        end while (avWaitrequest !== 1'b0);
        rd = avReaddata;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic lbXfer(input logic w, input logic [7:0] a,
            input logic [31:0] v, input logic [3:0] b);
        lbSel <= 1'b1;
        lbWrite <= w;
        lbAddress <= a;
        lbWdata <= v;
        lbByteEn <= b;
        @(posedge sys_clk);
        lbSel <= 1'b0;
    endtask
    // random op on DIR or OUT, legal lane sets only; model updated ahead
    task automatic draw;
        op = $random(seed);
        be = beTab[$unsigned($random(seed)) % 7];
        d = $random(seed);
        sel = $random(seed);
        ad = (sel ? `REG_OUT : `REG_DIR) + {op, 2'b00};
        if (sel) outM = apply(outM, d, be, op);
        else dirM = apply(dirM, d, be, op);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(5000 * 100);
        failures++;
        tally_and_finish;
    end
    initial begin
        seed = 32'h3b83;
        failures = 0;
        checkCount = 0;
        {avRead, avWrite, avDebugAccess, lbSel, lbWrite} = 5'h00;
        {writeGuard, dbgHalted} = 2'h0;
        {avAddress, lbAddress, avByteenable, lbByteEn} = 24'h000000;
        {avWritedata, lbWdata, periphOut, periphOe} = 128'h0;
        rst = 1'b0;
        #1 rst = 1'b1;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        check(padOe | padInEn | padPullEn, 32'h0);
        for (i = 0; i < 17; i++) begin
            avXfer(1'b0, 8'(i * 4), 32'h0, 4'hF);
            check(rd, `RESET_WORD);
        end
        $display("test reset: done");
        dirM = `RESET_WORD;
        outM = `RESET_WORD;
        for (i = 0; i < 24; i++) begin
            draw;
            avXfer(1'b1, ad, d, be);
            avXfer(1'b0, ad & 8'hF0, 32'h0, 4'hF);
            check(rd, sel ? outM : dirM);
        end
        check(padOe, dirM);
        check(padOut & dirM, outM & dirM);
        $display("test bridge set/clear/toggle: done");
        for (i = 0; i < 24; i++) begin
            draw;
            lbSel <= 1'b1;
            lbWrite <= 1'b1;
            lbAddress <= ad;
            lbByteEn <= be;
            lbWdata <= d;
            @(posedge sys_clk);
        end
        lbWrite <= 1'b0;
        lbAddress <= `REG_DIR;
        @(posedge sys_clk);
        lbAddress <= `REG_OUT;
        @(posedge sys_clk);
        check(lbRdata, dirM);
        lbSel <= 1'b0;
        @(posedge sys_clk);
        check(lbRdata, outM);
        $display("test local bus: done");
        avXfer(1'b1, `REG_OUT, outM, 4'hF);
        check(waitN, 2);
        fork
            avXfer(1'b1, `REG_OUTTGL, 32'h000000FF, 4'hF);
            lbXfer(1'b1, `REG_OUTSET, 32'h0000000F, 4'hF);
        join
        check(waitN, 3);
        outM = (outM | 32'h0000000F) ^ 32'h000000FF;
        avXfer(1'b0, `REG_OUT, 32'h0, 4'hF);
        check(rd, outM);
        $display("test collision: done");
        writeGuard <= 1'b1;
        avXfer(1'b1, `REG_DRIVE, 32'hA5A5A5A5, 4'hF);
        lbXfer(1'b1, `REG_DIR, ~dirM, 4'hF);
        avXfer(1'b0, `REG_DIR, 32'h0, 4'hF);
        check(rd, dirM);
        check(padDrive, `RESET_WORD);
        avDebugAccess <= 1'b1;
        avXfer(1'b1, `REG_DRIVE, 32'h5A5A5A5A, 4'hF);
        check(padDrive, 32'h5A5A5A5A);
        {writeGuard, avDebugAccess} <= 2'h0;
        $display("test write guard: done");
        avXfer(1'b1, `REG_DIR, 32'h0, 4'hF);
        pat = $random(seed);
        avXfer(1'b1, `REG_OUT, pat, 4'hF);
        avXfer(1'b1, `REG_PULLEN, 32'hFFFFFFFF, 4'hF);
        avXfer(1'b1, `REG_INEN, 32'hFFFFFFFF, 4'hF);
        check(padPullUp & padPullEn, pat);
        avXfer(1'b0, `REG_IN, 32'h0, 4'hF);
        check(waitN, 4);
        check(rd, pat);
        avXfer(1'b1, `REG_CTRL, 32'h0000000F, 4'hF);
        avXfer(1'b0, `REG_IN, 32'h0, 4'hF);
        check(waitN, 2);
        check(rd, pat);
        lbXfer(1'b0, `REG_IN, 32'h0, 4'hF);
        @(posedge sys_clk);
        check(lbRdata, pat);
        $display("test input sampling: done");
        d = $random(seed);
        periphOut <= d;
        periphOe <= 32'hFFFF0000;
        avXfer(1'b1, `REG_ROUTE, 32'hFFFF0000, 4'hF);
        avXfer(1'b1, `REG_ANALOG, 32'hFF0000FF, 4'hF);
        repeat (2) @(posedge sys_clk);
        check(padOe, 32'h00FF0000);
        check(padOut & 32'h00FF0000, d & 32'h00FF0000);
        check(padInEn, 32'h00FFFF00);
        check(padPullEn, 32'h0000FF00);
        check(periphIn, d & 32'h00FF0000);
        $display("test routing and analog: done");
        dbgHalted <= 1'b1;
        avXfer(1'b1, `REG_DIR, 32'h0000FF00, 4'hF);
        @(posedge sys_clk);
        check(padOe, 32'h00FFFF00);
        avXfer(1'b1, `REG_DBGHALT, 32'h00000001, 4'hF);
        avXfer(1'b1, `REG_DIR, 32'h0, 4'hF);
        @(posedge sys_clk);
        check(padOe, 32'h00FFFF00);
        dbgHalted <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(padOe, 32'h00FF0000);
        $display("test debug halt: done");
        tally_and_finish;
    end
endmodule // gpio_pin_group_controller_test
`default_nettype wire
